// [phd_defines.vh]
// Purpose: constants for the position and halt command decoder
// Assumes: byte-wide frame stream from a bus slave front end
// Notes:   definitions only
`ifndef PHD_DEFINES_VH
`define PHD_DEFINES_VH
// address byte fixed upper bits and write bit
`define PHD_ADDR_TOP      2'h3
`define PHD_ADDR_WRITE    1'h0
// command codes
`define PHD_CMD_ABS_MOVE  8'h8b
`define PHD_CMD_HALT      8'h8f
// filler byte value
`define PHD_FILLER        8'hff
// frame byte counts
`define PHD_LEN_ABS_MOVE  3'h6
`define PHD_LEN_HALT      3'h2
// byte positions inside a frame
`define PHD_IDX_ADDR      3'h0
`define PHD_IDX_CMD       3'h1
`define PHD_IDX_FILL1     3'h2
`define PHD_IDX_FILL2     3'h3
`define PHD_IDX_POS_HIGH  3'h4
`define PHD_IDX_POS_LOW   3'h5
`define PHD_IDX_LAST      3'h7
// target set-point after reset
`define PHD_TARGET_RESET  16'h0000
`endif

// [phd_position_halt_decoder.v]
// Purpose: decode absolute-move and gentle-halt command frames, steer motion
// Assumes: rxValid/rxData/frameStart/frameEnd come from same-clock bus logic
// Notes:   motion engine ramps velocity; this block owns the position set-points
//          frames within two edges of reset release see the address pin low
//
// Functional notes
// - an absolute move is address, code 8b, two ff fillers, set-point high, set-point low.
// - the set-point is signed 16 bits, high byte first after the fillers.
// - an accepted move drives the motor until actual position equals the absolute set-point.
// - a move is dropped without motion when the state logic marks it not accepted.
// - over-temperature raises a gentle halt internally with no bus frame.
// - a gentle halt ramps down to minimum velocity then stops, target reached or not.
// - after the halt stop the actual position is copied into the target position.
// - the bus gentle halt is address then code 8f, with no data bytes.
`timescale 1ns/1ps
`default_nettype none
`include "phd_defines.vh"
module phd_position_halt_decoder (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // byte stream of one bus write frame
    input  wire        frameStart,
    input  wire        rxValid,
    input  wire [7:0]  rxData,
    input  wire        frameEnd,
    // node identity
    input  wire        node_addr_bit3,
    input  wire        node_addr_bit2,
    input  wire        node_addr_bit1,
    input  wire        node_addr_bit0,
    input  wire        address_pin_bit,
    // state logic and motion engine
    input  wire        moveAccepted,
    input  wire        overTemp,
    input  wire        atMinVelocity,
    input  wire        motorStopped,
    input  wire [15:0] actual_position,
    // outputs to motion engine
    output reg  [15:0] target_position,
    output reg         moving,
    output reg         rampToMin,
    output reg         moveStartPulse,
    output reg         haltDonePulse
);
    // ---------------------------------------------------------------
    // frame capture
    // ---------------------------------------------------------------
    reg  [2:0]  byteCount;
    reg  [7:0]  cmdByte;
    reg  [7:0]  posHigh;
    reg  [7:0]  posLow;
    reg         addrOk;
    reg         fillOk;
    reg  [1:0]  tempSync;
    reg         tempSeen;
    reg  [1:0]  pinSync;
    wire [7:0]  ownAddr = {`PHD_ADDR_TOP, node_addr_bit3, node_addr_bit2,
                           node_addr_bit1, node_addr_bit0, pinSync[1], `PHD_ADDR_WRITE};

    // ---------------------------------------------------------------
    // address pin synchroniser
    // ---------------------------------------------------------------
    // the pin is outside the clock domain, two flops before the compare
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pinSync <= 2'h0;
        else
            pinSync <= {pinSync[0], address_pin_bit};
    end

    // byte counter, saturating so over-long frames stay invalid
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            byteCount <= 3'h0;
        else if (frameStart)
            byteCount <= 3'h0;
        else if (rxValid && byteCount != `PHD_IDX_LAST)
            byteCount <= byteCount + 3'h1;
    end

    // store fields by byte position
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdByte   <= 8'h00;
            posHigh   <= 8'h00;
            posLow    <= 8'h00;
            addrOk    <= 1'b0;
            fillOk    <= 1'b0;
        end else if (frameStart) begin
            addrOk    <= 1'b0;
            fillOk    <= 1'b1;
        end else if (rxValid) begin
            case (byteCount)
                `PHD_IDX_ADDR: addrOk <= (rxData == ownAddr);
                `PHD_IDX_CMD: cmdByte <= rxData;
                `PHD_IDX_FILL1, `PHD_IDX_FILL2: if (rxData != `PHD_FILLER) fillOk <= 1'b0;
                `PHD_IDX_POS_HIGH: posHigh <= rxData;
                `PHD_IDX_POS_LOW: posLow <= rxData;
                default: fillOk <= fillOk;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // command decode at frame end
    // ---------------------------------------------------------------
    // six-byte move frame
    wire moveCmd = frameEnd && addrOk && fillOk && cmdByte == `PHD_CMD_ABS_MOVE
                   && byteCount == `PHD_LEN_ABS_MOVE;
    wire busHalt = frameEnd && addrOk && cmdByte == `PHD_CMD_HALT
                   && byteCount == `PHD_LEN_HALT;

    // ---------------------------------------------------------------
    // over-temperature
    // ---------------------------------------------------------------
    // over-temperature synchroniser and rising edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tempSync <= 2'h0;
            tempSeen <= 1'b0;
        end else begin
            tempSync <= {tempSync[0], overTemp};
            tempSeen <= tempSync[1];
        end
    end
    wire tempHalt = tempSync[1] && !tempSeen;
    wire haltReq = busHalt || tempHalt;

    // ---------------------------------------------------------------
    // motion control state
    // ---------------------------------------------------------------
    // one-hot codes: idle, moving to a set-point, ramping for a halt
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_MOVE = 3'b010;
    localparam [2:0] ST_HALT = 3'b100;
    reg [2:0] state;
    reg [2:0] next_state;

    // next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (haltReq)
                    next_state = ST_HALT;
                else if (moveCmd && moveAccepted)
                    next_state = ST_MOVE;
            end
            ST_MOVE: begin
                if (haltReq)
                    next_state = ST_HALT;
                else if (actual_position == target_position)
                    next_state = ST_IDLE;
            end
            ST_HALT: begin
                if (motorStopped && atMinVelocity)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // transitions that load the target and fire the pulses
    wire enterMove = (state == ST_IDLE) && (next_state == ST_MOVE);
    wire leaveHalt = (state == ST_HALT) && (next_state == ST_IDLE);

    // state register
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ---------------------------------------------------------------
    // outputs to the motion engine
    // ---------------------------------------------------------------
    // target set-point, written on move start or halt end only
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_position <= `PHD_TARGET_RESET;
        end else if (enterMove) begin
            target_position <= {posHigh, posLow};
        end else if (leaveHalt) begin
            target_position <= actual_position;
        end
    end

    // one-cycle pulses for move start and halt end
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            moveStartPulse <= 1'b0;
            haltDonePulse  <= 1'b0;
        end else begin
            moveStartPulse <= enterMove;
            haltDonePulse  <= leaveHalt;
        end
    end

    // level outputs follow the next state
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            moving    <= 1'b0;
            rampToMin <= 1'b0;
        end else begin
            moving    <= (next_state == ST_MOVE);
            rampToMin <= (next_state == ST_HALT);
        end
    end
endmodule // phd_position_halt_decoder
`default_nettype wire

// [phd_bus_master.sv]
// Purpose: bus master model feeding write frames
// Assumes: frame word left aligned, first byte on top
// Notes:   idle data line shows the inverse byte
`timescale 1ns/1ps
`default_nettype none
module phd_bus_master (
    // clock
    input  wire logic       sys_clk,
    // frame byte stream
    output var  logic       frameStart,
    output var  logic       rxValid,
    output var  logic       frameEnd,
    output var  logic [7:0] rxData
);
    initial {frameStart, rxValid, frameEnd, rxData} = 11'h000;
    task automatic send(input int n, input logic [47:0] f);
        @(posedge sys_clk) frameStart <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk) frameStart <= 1'b0;
            {rxValid, rxData} <= {1'b1, f[47-8*i -: 8]};
        end
        @(posedge sys_clk) {rxValid, rxData, frameEnd} <= {1'b0, ~rxData, 1'b1};
        @(posedge sys_clk) frameEnd <= 1'b0;
    endtask
endmodule // phd_bus_master
`default_nettype wire

// [phd_position_halt_decoder_checker.sv]
// Purpose: port assertions of the decoder
// Assumes: one clock, async low reset
// Notes:   bound from the bench
`timescale 1ns/1ps
`default_nettype none
module phd_position_halt_decoder_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // frame end, state logic and motion engine
    input wire logic        frameEnd,
    input wire logic        moveAccepted,
    input wire logic        overTemp,
    input wire logic        atMinVelocity,
    input wire logic        motorStopped,
    input wire logic [15:0] actual_position,
    // decoder outputs
    input wire logic        moving,
    input wire logic        rampToMin,
    input wire logic        moveStartPulse,
    input wire logic        haltDonePulse,
    input wire logic [15:0] target_position
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_start_cause: assert property (
        moveStartPulse |-> $past(frameEnd && moveAccepted)) else $error("start without frame");
    a_start_pulse: assert property (
        moveStartPulse |-> moving ##1 !moveStartPulse) else $error("bad start pulse");
    a_move_ends: assert property (
        moving && actual_position == target_position |=> !moving) else $error("move not ended");
    a_halt_stops: assert property (
        rampToMin |-> !moving) else $error("moving in halt");
    a_ramp_holds: assert property (
        rampToMin && !(motorStopped && atMinVelocity) |=> rampToMin) else $error("ramp dropped");
    a_done_cause: assert property (
        haltDonePulse |-> $past(rampToMin && motorStopped && atMinVelocity)) else $error("early done");
    a_done_copies: assert property (
        haltDonePulse |-> target_position == $past(actual_position)) else $error("stop lost");
    a_temp_halt: assert property (
        $rose(overTemp) |-> ##[1:5] rampToMin) else $error("no thermal halt");
endmodule // phd_position_halt_decoder_checker
`default_nettype wire

// [phd_position_halt_decoder_tb.sv]
// Purpose: self-checking bench of the decoder
// Assumes: node bits a, pin bit 1, address byte ea
// Notes:   outputs read 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module phd_position_halt_decoder_tb;
    logic        sys_clk = 1'b0, rst_n = 1'b0, moveAccepted = 1'b0, overTemp = 1'b0;
    logic        atMinVelocity = 1'b0, motorStopped = 1'b0, frameStart, rxValid, frameEnd;
    logic        moving, rampToMin, moveStartPulse, haltDonePulse;
    logic [7:0]  rxData;
    logic [15:0] actual_position = 16'h0000, target_position;
    logic [3:0]  nodeAddr = 4'ha;
    logic        addressPinBit = 1'b1;
    int          fail_count = 0, n_tests = 0;
    always #12.5 sys_clk = ~sys_clk;
    phd_bus_master bm (
        .sys_clk    (sys_clk),
        .frameStart (frameStart),
        .rxValid    (rxValid),
        .frameEnd   (frameEnd),
        .rxData     (rxData)
    );
    phd_position_halt_decoder dut (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .frameStart      (frameStart),
        .rxValid         (rxValid),
        .rxData          (rxData),
        .frameEnd        (frameEnd),
        .node_addr_bit3  (nodeAddr[3]),
        .node_addr_bit2  (nodeAddr[2]),
        .node_addr_bit1  (nodeAddr[1]),
        .node_addr_bit0  (nodeAddr[0]),
        .address_pin_bit (addressPinBit),
        .moveAccepted    (moveAccepted),
        .overTemp        (overTemp),
        .atMinVelocity   (atMinVelocity),
        .motorStopped    (motorStopped),
        .actual_position (actual_position),
        .target_position (target_position),
        .moving          (moving),
        .rampToMin       (rampToMin),
        .moveStartPulse  (moveStartPulse),
        .haltDonePulse   (haltDonePulse)
    );
    task automatic chk(string n, logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // stopped motor at minimum velocity ends a halt
    task automatic stop_at(logic [15:0] p);
        @(posedge sys_clk) {actual_position, motorStopped} <= {p, 1'b1};
        @(posedge sys_clk) atMinVelocity <= 1'b1;
        #1 chk("rampToMin", 1, rampToMin);
        @(posedge sys_clk) {motorStopped, atMinVelocity} <= 2'h0;
        #1 chk("haltDonePulse", 1, haltDonePulse);
        chk("target_position", p, target_position);
    endtask
    task automatic t_refuse();
        logic [47:0] f [5] = '{48'hea8bffff1234, 48'heb8bffff1234, 48'hea8bff7f1234,
            48'hea8cffff1234, 48'hea8f00000000};
        foreach (f[i]) begin
            @(posedge sys_clk) moveAccepted <= (i > 0);
            bm.send(6, f[i]);
            #1 chk("moveStartPulse", 0, moveStartPulse);
            chk("rampToMin", 0, rampToMin);
        end
        $display("refuse test end");
    endtask
    task automatic t_move();
        bm.send(6, 48'hea8bffff8005);
        #1 chk("target_position", 16'h8005, target_position);
        chk("moveStartPulse", 1, moveStartPulse);
        bm.send(2, 48'hea8f00000000);
        #1 chk("rampToMin", 1, rampToMin);
        chk("moving", 0, moving);
        stop_at(16'h0040);
        bm.send(6, 48'hea8bffff0040);
        #1 chk("moving", 1, moving);
        @(posedge sys_clk) #1 chk("moving", 0, moving);
        $display("move test end");
    endtask
    // other node and pin bits give address byte d4
    task automatic t_pin();
        @(posedge sys_clk) {nodeAddr, addressPinBit} <= {4'h5, 1'b0};
        bm.send(6, 48'hea8bffff0100);
        #1 chk("moveStartPulse", 0, moveStartPulse);
        bm.send(2, 48'hd48f00000000);
        #1 chk("rampToMin", 1, rampToMin);
        stop_at(16'h0100);
        @(posedge sys_clk) {nodeAddr, addressPinBit} <= {4'ha, 1'b1};
        $display("pin test end");
    endtask
    task automatic t_temp();
        @(posedge sys_clk) overTemp <= 1'b1;
        for (int i = 0; i < 8 && rampToMin !== 1'b1; i++) @(posedge sys_clk) #1;
        chk("rampToMin", 1, rampToMin);
        if (rampToMin !== 1'b1) end_of_test();
        stop_at(16'h7ffe);
        $display("thermal test end");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_refuse();
        t_move();
        t_pin();
        t_temp();
        end_of_test();
    end
endmodule // phd_position_halt_decoder_tb
bind phd_position_halt_decoder phd_position_halt_decoder_checker u_chk (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .frameEnd        (frameEnd),
    .moveAccepted    (moveAccepted),
    .overTemp        (overTemp),
    .atMinVelocity   (atMinVelocity),
    .motorStopped    (motorStopped),
    .actual_position (actual_position),
    .moving          (moving),
    .rampToMin       (rampToMin),
    .moveStartPulse  (moveStartPulse),
    .haltDonePulse   (haltDonePulse),
    .target_position (target_position)
);
`default_nettype wire
